// ### dv/dss_ctrl_checker.sv
// Checker of selection and health flag relations at the control block ports.
module dss_ctrl_checker #(
    parameter int HOLD_CYC = dss_pkg::HOLD_CYC,
    parameter int FILT_WIN = dss_pkg::FILT_WIN
) (
    // Clock and reset.
    input  wire logic               ref_clk_in,
    input  wire logic               rst_in,
    // Observed ports.
    input  wire dss_pkg::dss_sense_t sense_in,
    input  wire logic               switch_a_on_out,
    input  wire logic               switch_b_on_out,
    input  wire logic               selected_ind_a_n_oe_n_out,
    input  wire logic               selected_ind_b_n_oe_n_out,
    input  wire logic               health_flag_a_n_oe_n_out,
    input  wire logic               health_flag_b_n_oe_n_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);
    sw_excl_a: assert property (!(switch_a_on_out && switch_b_on_out)) else $error("both switches on");
    ind_a_match_a: assert property (selected_ind_a_n_oe_n_out == !switch_a_on_out)
        else $error("indicator a differs from switch a");
    ind_b_match_a: assert property (selected_ind_b_n_oe_n_out == !switch_b_on_out)
        else $error("indicator b differs from switch b");
    hot_off_a: assert property (sense_in.overtemp |=> !switch_a_on_out && !switch_b_on_out)
        else $error("switch on during overtemperature");
    hot_flag_a: assert property (sense_in.overtemp && sense_in.a_present && sense_in.b_present
        |=> !health_flag_a_n_oe_n_out && !health_flag_b_n_oe_n_out) else $error("flags idle in overtemperature");
    absent_a_a: assert property (!sense_in.a_present |=> health_flag_a_n_oe_n_out)
        else $error("flag a driven without supply a");
    undervoltage_lockout_flag_a: assert property (sense_in.a_present && !sense_in.a_above_undervoltage_lockout |=> !health_flag_a_n_oe_n_out)
        else $error("flag a idle under lockout");
    valid_a_a: assert property (switch_a_on_out |-> $past(sense_in.a_above_undervoltage_lockout && !sense_in.overtemp))
        else $error("switch a on without valid supply");
    valid_b_a: assert property (switch_b_on_out |-> $past(sense_in.b_above_undervoltage_lockout && !sense_in.overtemp))
        else $error("switch b on without valid supply");
endmodule // dss_ctrl_checker

// ### dv/dss_supply_model.sv
// Model of the two supplies and the pulled-up status lines around the control block.
module dss_supply_model (
    // Clock and supply conditions.
    input  wire logic                ref_clk_in,
    input  wire dss_pkg::dss_sense_t src_in,
    // Open-drain drives, order ind_a, ind_b, flag_a, flag_b.
    input  wire logic [3:0]          od_in,
    input  wire logic [3:0]          od_oe_n_in,
    // Results toward the block.
    output dss_pkg::dss_sense_t      sense_out,
    output logic [3:0]               pin_out
);
    // Monitor results pass a register so they arrive as clean synchronous bits.
    always_ff @(posedge ref_clk_in) begin
        sense_out <= src_in;
    end
    // Every line has a pull-up, so a released line reads high.
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_out[i] = od_oe_n_in[i] ? 1'b1 : od_in[i];
        end
    end
endmodule // dss_supply_model

// ### dv/tb_dss_ctrl.sv
// Self-checking bench of the dual supply select control.
module tb_dss_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    // ========================================================================
    // Signals.
    logic                ref_clk_in = 1'b0;
    logic                rst_in     = 1'b1;
    logic                pa         = 1'b0;
    logic                pb         = 1'b0;
    dss_pkg::dss_sense_t src        = 8'he3;
    dss_pkg::dss_sense_t sense;
    logic                sw_a, sw_b;
    logic [3:0]          od, oe, pins;
    logic [3:0]          addr  = 4'h0;
    logic [31:0]         wdata = 32'h0;
    logic                wr    = 1'b0;
    logic                rd    = 1'b0;
    logic [31:0]         rdata;
    int                  fails = 0, compares = 0, cycles = 0;
    logic [1:0]          code [4] = '{2'b01, 2'b11, 2'b10, 2'b00};
    logic [1:0]          ex   [5] = '{2'b01, 2'b00, 2'b01, 2'b10, 2'b01};
    always #5 ref_clk_in = ~ref_clk_in;
    dss_supply_model i_model (.ref_clk_in(ref_clk_in), .src_in(src), .od_in(od), .od_oe_n_in(oe),
        .sense_out(sense), .pin_out(pins));
    dss_ctrl #(.HOLD_CYC(20), .FILT_WIN(64)) i_dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .select_pin_a_in(pa), .select_pin_b_in(pb), .sense_in(sense), .switch_a_on_out(sw_a), .switch_b_on_out(sw_b),
        .selected_ind_a_n_in(pins[0]), .selected_ind_a_n_out(od[0]), .selected_ind_a_n_oe_n_out(oe[0]),
        .selected_ind_b_n_in(pins[1]), .selected_ind_b_n_out(od[1]), .selected_ind_b_n_oe_n_out(oe[1]),
        .health_flag_a_n_in(pins[2]), .health_flag_a_n_out(od[2]), .health_flag_a_n_oe_n_out(oe[2]),
        .health_flag_b_n_in(pins[3]), .health_flag_b_n_out(od[3]), .health_flag_b_n_oe_n_out(oe[3]),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));
    // ========================================================================
    // Tasks; all but chk and summarize end on a rising edge so the next drive lands just after it.
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic outs(input logic [1:0] e);
        #1 chk({sw_a, sw_b, pins[1:0]}, {e, ~e[0], ~e[1]});
        cyc(1);
    endtask
    task automatic pin(input int i, input logic e);
        #1 chk(pins[i], e);
        cyc(1);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        cyc(1);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
        addr <= a;
        rd <= 1'b1;
        cyc(1);
        rd <= 1'b0;
        #1 chk(rdata, e);
        cyc(1);
    endtask
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            summarize();
        end
    end
    // ========================================================================
    // Tests.
    initial begin
        cyc(3);
        rst_in <= 1'b0;
        cyc(4);
        outs(2'b10);
        src.a_higher <= 1'b0;
        cyc(4);
        outs(2'b01);
        wr_reg(dss_pkg::REG_CTRL, 32'h1);
        src.a_higher <= 1'b1;
        cyc(4);
        outs(2'b01);
        rd_chk(dss_pkg::REG_CTRL, 32'h1);
        wr_reg(dss_pkg::REG_CTRL, 32'h0);
        cyc(4);
        outs(2'b10);
        src.limit_b <= 1'b1;
        src.a_higher <= 1'b0;
        cyc(4);
        outs(2'b10);
        src.limit_b <= 1'b0;
        cyc(4);
        outs(2'b01);
        rd_chk(4'hc, 32'h0);
        $display("test auto done");
        for (int i = 0; i < 4; i++) begin
            pa <= code[i][1];
            pb <= code[i][0];
            cyc(990);
            outs(ex[i]);
            cyc(20);
            outs(ex[i + 1]);
            if (code[i] == 2'b10) rd_chk(dss_pkg::REG_STATUS, 32'h6);
        end
        $display("test manual done");
        pa <= 1'b1;
        pb <= 1'b0;
        cyc(1010);
        outs(2'b10);
        src.a_above_undervoltage_lockout <= 1'b0;
        cyc(4);
        outs(2'b00);
        pin(2, 1'b0);
        src.a_above_undervoltage_lockout <= 1'b1;
        pb <= 1'b1;
        cyc(1010);
        outs(2'b01);
        pa <= 1'b0;
        pb <= 1'b0;
        cyc(1010);
        src.a_above_undervoltage_lockout <= 1'b0;
        src.b_above_undervoltage_lockout <= 1'b0;
        cyc(4);
        outs(2'b00);
        pin(3, 1'b0);
        src.a_present <= 1'b0;
        cyc(4);
        pin(2, 1'b1);
        src <= 8'he7;
        cyc(4);
        outs(2'b00);
        pin(2, 1'b0);
        src <= 8'hc3;
        cyc(6);
        $display("test supply done");
        src.limit_a <= 1'b1;
        cyc(12);
        pin(2, 1'b1);
        cyc(14);
        pin(2, 1'b0);
        src.limit_a <= 1'b0;
        cyc(90);
        pin(2, 1'b1);
        for (int i = 0; i < 160; i++) begin
            src.limit_a <= (i % 4) != 3;
            cyc(1);
        end
        pin(2, 1'b0);
        rd_chk(dss_pkg::REG_STATUS, 32'h28);
        rd_chk(dss_pkg::REG_PINS, 32'h9);
        $display("test filter done");
        summarize();
    end
endmodule // tb_dss_ctrl

bind dss_ctrl dss_ctrl_checker #(.HOLD_CYC(HOLD_CYC), .FILT_WIN(FILT_WIN)) i_chk (.ref_clk_in(ref_clk_in),
    .rst_in(rst_in), .sense_in(sense_in), .switch_a_on_out(switch_a_on_out), .switch_b_on_out(switch_b_on_out),
    .selected_ind_a_n_oe_n_out(selected_ind_a_n_oe_n_out), .selected_ind_b_n_oe_n_out(selected_ind_b_n_oe_n_out),
    .health_flag_a_n_oe_n_out(health_flag_a_n_oe_n_out), .health_flag_b_n_oe_n_out(health_flag_b_n_oe_n_out));

// ### rtl/dss_ctrl.sv
// Control logic of a two input supply selector with health and selection flags.
// Behaviour
// R1: Both select pins low: connect higher valid supply.
// R2: Code A low, B high: connect nothing.
// R3: Code A high, B low: connect A if valid.
// R4: Both pins high: connect B if valid.
// R5: Apply new select code 10 us after change.
// R6: Both supplies under lockout: connect nothing.
// R7: No-input mode keeps both switches off.
// R8: Current limit blocks automatic switchover, not manual.
// R9: Limit onset feeds the channel health filter.
// R10: Overtemperature: both switches off, both flags low.
// R11: Flag after 50% duty or 5 ms limit.
// R12: Flag held 5 ms or until duty low.
// R13: Indicator low exactly while its supply connected.
// R14: Both indicators released when nothing connected.
// R15: Flag A released when supply A absent.
// R16: Single line control: A high, B chooses.
// R17: Health flag low while supply under lockout.
// R18: Sensed results enter as synchronous bits.
module dss_ctrl #(
    parameter int HOLD_CYC = dss_pkg::HOLD_CYC,
    parameter int FILT_WIN = dss_pkg::FILT_WIN
) (
    // Clock and reset.
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_in,
    // Select pins.
    input  wire logic                      select_pin_a_in,
    input  wire logic                      select_pin_b_in,
    // Analog monitor results.
    input  wire dss_pkg::dss_sense_t       sense_in,
    // Channel switches.
    output logic                           switch_a_on_out,
    output logic                           switch_b_on_out,
    // Open-drain selection indicators.
    input  wire logic                      selected_ind_a_n_in,
    output logic                           selected_ind_a_n_out,
    output logic                           selected_ind_a_n_oe_n_out,
    input  wire logic                      selected_ind_b_n_in,
    output logic                           selected_ind_b_n_out,
    output logic                           selected_ind_b_n_oe_n_out,
    // Open-drain health flags.
    input  wire logic                      health_flag_a_n_in,
    output logic                           health_flag_a_n_out,
    output logic                           health_flag_a_n_oe_n_out,
    input  wire logic                      health_flag_b_n_in,
    output logic                           health_flag_b_n_out,
    output logic                           health_flag_b_n_oe_n_out,
    // Register port.
    input  wire logic [dss_pkg::ADDR_W-1:0] reg_addr_in,
    input  wire logic [31:0]               reg_wdata_in,
    input  wire logic                      reg_wr_in,
    input  wire logic                      reg_rd_in,
    output logic [31:0]                    reg_rdata_out
);

    // ========================================================================
    // State.
    typedef struct packed {
        // Select pins as last sampled, and the settling timer.
        logic                           pin_a_q;
        logic                           pin_b_q;
        logic [dss_pkg::SETTLE_W-1:0]   settle;
        logic                           settling;
        // Applied mode and current connection.
        dss_pkg::dss_mode_t             mode;
        dss_pkg::dss_sel_t              sel;
        // Current-limit filters of both channels.
        dss_pkg::dss_filt_t             fa;
        dss_pkg::dss_filt_t             fb;
        // Software control and the read data register.
        logic                           auto_hold;
        logic [31:0]                    rdata;
        // Registered drives of the switches and the open-drain pins.
        logic                           sw_a;
        logic                           sw_b;
        logic                           ind_a_oe_n;
        logic                           ind_b_oe_n;
        logic                           hf_a_oe_n;
        logic                           hf_b_oe_n;
        logic                           od_level;
    } dss_state_t;

    // Counter limits are cut to the counter width on purpose; the parameters
    // must stay below two to the power of the counter width.
    // The settle timer ends on its last count, so the code is applied after
    // exactly the settling count of cycles without a further compare stage.
    localparam logic [dss_pkg::CNT_W-1:0] HOLD_LIM = dss_pkg::CNT_W'(HOLD_CYC);
    localparam logic [dss_pkg::CNT_W-1:0] WIN_LAST = dss_pkg::CNT_W'(FILT_WIN - 1);
    localparam logic [dss_pkg::CNT_W-1:0] WIN_HALF = dss_pkg::CNT_W'(FILT_WIN / 2);
    localparam logic [dss_pkg::SETTLE_W-1:0] SETTLE_LAST =
        dss_pkg::SETTLE_W'(dss_pkg::SETTLE_CYC - 1);

    dss_state_t st;
    dss_state_t next_st;

    // ========================================================================
    // Helpers.

    // Saturating increment, so long quiet periods never wrap a counter.
    function automatic logic [dss_pkg::CNT_W-1:0] sat_inc(
        input logic [dss_pkg::CNT_W-1:0] v
    );
        sat_inc = (v == {dss_pkg::CNT_W{1'b1}}) ? v : v + 1'b1;
    endfunction

    // Status word as software sees it. The layout is kept in one place so
    // that the bench and the software view cannot drift apart inside here.
    function automatic logic [31:0] status_word(
        input dss_state_t s,
        input logic       hot
    );
        status_word      = '0;
        status_word[1:0] = s.mode;
        status_word[3:2] = s.sel;
        status_word[4]   = s.settling;
        status_word[5]   = s.fa.flag;
        status_word[6]   = s.fb.flag;
        status_word[7]   = hot;
    endfunction

    // Pin readback word: the open-drain lines as they stand outside, then
    // the select code as last sampled.
    function automatic logic [31:0] pins_word(
        input logic [3:0] od_pins,
        input logic       pin_a,
        input logic       pin_b
    );
        pins_word      = '0;
        pins_word[3:0] = od_pins;
        pins_word[4]   = pin_a;
        pins_word[5]   = pin_b;
    endfunction

    // One step of the current-limit flag filter. A short spike neither
    // raises nor drops the flag; the window counts duty, the run counts
    // continuous time.
    // Window and run use separate counters: a flag that follows long periods
    // at high duty and a flag that follows one long event must both come up,
    // and either may happen first.
    function automatic dss_pkg::dss_filt_t filt_step(
        input dss_pkg::dss_filt_t f,
        input logic               lim
    );
        dss_pkg::dss_filt_t n;
        logic               win_end;
        logic [dss_pkg::CNT_W-1:0] on_total;
        logic               duty_hi;
        logic               duty_lo;
        n        = f;
        win_end  = (f.win_cnt == WIN_LAST);
        on_total = f.on_cnt + dss_pkg::CNT_W'(lim);
        duty_hi  = win_end && (on_total > WIN_HALF);
        duty_lo  = win_end && !duty_hi;
        n.run    = lim ? sat_inc(f.run) : '0;
        n.off    = lim ? '0 : sat_inc(f.off);
        if (win_end) begin
            n.win_cnt = '0;
            n.on_cnt  = '0;
        end else begin
            n.win_cnt = f.win_cnt + 1'b1;
            n.on_cnt  = on_total;
        end
        if (n.run >= HOLD_LIM || duty_hi) begin  // [R11]
            n.flag = 1'b1;
        end else if (f.flag && (n.off >= HOLD_LIM || duty_lo)) begin  // [R12]
            n.flag = 1'b0;
        end
        filt_step = n;
    endfunction

    // ========================================================================
    // Next state.
    // Intermediate values of the next-state logic; all are set at the top.
    logic     code_changed;
    logic     a_ok;
    logic     b_ok;
    logic     in_limit;
    dss_pkg::dss_sel_t auto_pick;
    dss_pkg::dss_sel_t sel_new;
    logic     hf_a_low;
    logic     hf_b_low;

    always_comb begin
        next_st      = st;
        code_changed = (select_pin_a_in != st.pin_a_q) || (select_pin_b_in != st.pin_b_q);
        a_ok         = sense_in.a_above_undervoltage_lockout;  // [R18]
        b_ok         = sense_in.b_above_undervoltage_lockout;
        in_limit     = sense_in.limit_a || sense_in.limit_b;
        auto_pick    = dss_pkg::SEL_NONE;
        sel_new      = dss_pkg::SEL_NONE;
        hf_a_low     = 1'b0;
        hf_b_low     = 1'b0;

        // ====================================================================
        // Select code settling.
        // Any edge on either pin restarts the wait, so two pins that move a
        // little apart are taken as one change and no passing code is applied.
        next_st.pin_a_q = select_pin_a_in;
        next_st.pin_b_q = select_pin_b_in;
        if (code_changed) begin  // [R5]
            next_st.settling = 1'b1;
            next_st.settle   = '0;
        end else if (st.settling) begin
            if (st.settle == SETTLE_LAST) begin  // [R5]
                next_st.settling = 1'b0;
                next_st.mode     = dss_pkg::dss_mode_t'({st.pin_a_q, st.pin_b_q});
            end else begin
                next_st.settle = st.settle + 1'b1;
            end
        end

        // ====================================================================
        // Selection.
        // Automatic choice of the higher valid supply. The comparator result
        // already carries its hysteresis, so no extra margin is applied here.
        if (a_ok && b_ok) begin  // [R1]
            auto_pick = sense_in.a_higher ? dss_pkg::SEL_A : dss_pkg::SEL_B;
        end else if (a_ok) begin
            auto_pick = dss_pkg::SEL_A;
        end else if (b_ok) begin
            auto_pick = dss_pkg::SEL_B;
        end else begin
            auto_pick = dss_pkg::SEL_NONE;  // [R6]
        end

        // Loading the other supply during a limit event would make the
        // comparator swing back and forth, so a live channel is kept.
        // Only a swap between two valid supplies is held back; losing the
        // lockout level on the live channel still moves the selection.
        if (a_ok && b_ok && st.sel != dss_pkg::SEL_NONE && auto_pick != st.sel
            && (in_limit || st.auto_hold)) begin  // [R8]
            auto_pick = st.sel;
        end

        unique case (st.mode)
            dss_pkg::MODE_AUTO: begin
                sel_new = auto_pick;  // [R1]
            end
            dss_pkg::MODE_NONE: begin
                sel_new = dss_pkg::SEL_NONE;  // [R2] [R7]
            end
            dss_pkg::MODE_A: begin
                sel_new = a_ok ? dss_pkg::SEL_A : dss_pkg::SEL_NONE;  // [R3] [R16]
            end
            dss_pkg::MODE_B: begin
                sel_new = b_ok ? dss_pkg::SEL_B : dss_pkg::SEL_NONE;  // [R4] [R16]
            end
        endcase
        // Overtemperature wins over every mode; the code itself is kept, so
        // the selection comes back on its own once the die has cooled.
        if (sense_in.overtemp) begin
            sel_new = dss_pkg::SEL_NONE;  // [R10]
        end
        next_st.sel  = sel_new;
        next_st.sw_a = (sel_new == dss_pkg::SEL_A);  // [R7]
        next_st.sw_b = (sel_new == dss_pkg::SEL_B);

        // Indicators follow the switches in the same cycle.
        // A released indicator is pulled high outside, which reads as its supply not connected.
        next_st.ind_a_oe_n = (sel_new != dss_pkg::SEL_A);  // [R13] [R14]
        next_st.ind_b_oe_n = (sel_new != dss_pkg::SEL_B);  // [R13] [R14]

        // ====================================================================
        // Health flags.
        // Lockout and overtemperature act at once; only current limit goes
        // through the filter, since short load spikes must not raise a flag.
        next_st.fa = filt_step(st.fa, sense_in.limit_a);  // [R9]
        next_st.fb = filt_step(st.fb, sense_in.limit_b);  // [R9]
        hf_a_low   = next_st.fa.flag || sense_in.overtemp || !a_ok;  // [R10] [R17]
        hf_b_low   = next_st.fb.flag || sense_in.overtemp || !b_ok;  // [R10] [R17]
        // The flag logic lives on its own supply; without it the pin floats.
        next_st.hf_a_oe_n = !(hf_a_low && sense_in.a_present);  // [R15]
        next_st.hf_b_oe_n = !(hf_b_low && sense_in.b_present);
        next_st.od_level  = 1'b0;

        // ====================================================================
        // Register port.
        // Read data stand for one cycle only and are zero otherwise, so a bus
        // that ORs several slaves needs no extra select logic.
        next_st.rdata = '0;
        if (reg_wr_in && reg_addr_in == dss_pkg::REG_CTRL) begin
            next_st.auto_hold = reg_wdata_in[dss_pkg::CTRL_HOLD_B];
        end
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                dss_pkg::REG_CTRL: begin
                    next_st.rdata[dss_pkg::CTRL_HOLD_B] = st.auto_hold;
                end
                dss_pkg::REG_STATUS: begin
                    next_st.rdata = status_word(st, sense_in.overtemp);
                end
                dss_pkg::REG_PINS: begin
                    next_st.rdata = pins_word({health_flag_b_n_in, health_flag_a_n_in,
                                               selected_ind_b_n_in, selected_ind_a_n_in},
                                              st.pin_a_q, st.pin_b_q);
                end
                default: next_st.rdata = '0;
            endcase
        end
    end

    // ========================================================================
    // Registers.
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            // Every drive starts released and no channel is connected, so a
            // reset never glitches a supply onto the output.
            st            <= '0;
            st.mode       <= dss_pkg::MODE_AUTO;
            st.sel        <= dss_pkg::SEL_NONE;
            st.auto_hold  <= dss_pkg::CTRL_RESET;
            st.ind_a_oe_n <= 1'b1;
            st.ind_b_oe_n <= 1'b1;
            st.hf_a_oe_n  <= 1'b1;
            st.hf_b_oe_n  <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================================
    // Outputs.
    // Every output is a register bit. The open-drain value is always low and
    // only the enables move, so a pin is never driven high; a user must fit
    // a pull-up on every status line.
    assign switch_a_on_out           = st.sw_a;
    assign switch_b_on_out           = st.sw_b;
    assign selected_ind_a_n_out      = st.od_level;
    assign selected_ind_a_n_oe_n_out = st.ind_a_oe_n;
    assign selected_ind_b_n_out      = st.od_level;
    assign selected_ind_b_n_oe_n_out = st.ind_b_oe_n;
    assign health_flag_a_n_out       = st.od_level;
    assign health_flag_a_n_oe_n_out  = st.hf_a_oe_n;
    assign health_flag_b_n_out       = st.od_level;
    assign health_flag_b_n_oe_n_out  = st.hf_b_oe_n;
    assign reg_rdata_out             = st.rdata;

endmodule // dss_ctrl

// ### rtl/dss_pkg.sv
// Package with types and constants of the dual supply select control.
package dss_pkg;

    // ========================================================================
    // Timing.
    localparam int CLK_MHZ     = 100;
    localparam int SETTLE_US   = 10;
    localparam int SETTLE_CYC  = SETTLE_US * CLK_MHZ;
    localparam int HOLD_MS     = 5;
    localparam int HOLD_CYC    = HOLD_MS * 1000 * CLK_MHZ;
    localparam int FILT_WIN_MS = 10;
    localparam int FILT_WIN    = FILT_WIN_MS * 1000 * CLK_MHZ;
    localparam int CNT_W       = 20;
    localparam int SETTLE_W    = 10;

    // ========================================================================
    // Register map.
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  REG_CTRL    = 4'h0;
    localparam logic [3:0]  REG_STATUS  = 4'h4;
    localparam logic [3:0]  REG_PINS    = 4'h8;
    localparam int          CTRL_HOLD_B = 0;
    localparam logic        CTRL_RESET  = 1'b0;

    // ========================================================================
    // Types.
    typedef enum logic [1:0] {
        MODE_AUTO = 2'b00,
        MODE_NONE = 2'b01,
        MODE_A    = 2'b10,
        MODE_B    = 2'b11
    } dss_mode_t;

    typedef enum logic [1:0] {
        SEL_NONE = 2'b00,
        SEL_A    = 2'b01,
        SEL_B    = 2'b10
    } dss_sel_t;

    typedef struct packed {
        logic a_above_undervoltage_lockout;
        logic b_above_undervoltage_lockout;
        logic a_higher;
        logic limit_a;
        logic limit_b;
        logic overtemp;
        logic a_present;
        logic b_present;
    } dss_sense_t;

    typedef struct packed {
        logic [CNT_W-1:0] run;
        logic [CNT_W-1:0] off;
        logic [CNT_W-1:0] win_cnt;
        logic [CNT_W-1:0] on_cnt;
        logic             flag;
    } dss_filt_t;

endpackage
